// ### verif/sdc_dac_if_tb_top.sv
// Self-checking testbench of the serial converter front end
`timescale 1ns/1ps
module sdc_dac_if_tb_top;
    import sdc_pkg::*;

    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        din;
    logic        cs_n;
    sdc_value_t  conv_value;
    logic        shutdown;
    logic        output_settled;
    int          fail_count;
    int          n_compared;
    logic [31:0] rd;
    logic        er;

    typedef struct {
        logic [15:0] frame;
        logic        split;
        logic [12:0] exp_in;
        logic [12:0] exp_conv;
        logic        exp_sd;
    } sdc_row_t;

    sdc_row_t rows[8] = '{
        '{16'h0aa8, 1'b0, 13'h0aa8, 13'h0aa8, 1'b0},  // Load both, sub bits zero
        '{16'h3550, 1'b0, 13'h1550, 13'h0aa8, 1'b0},  // Load input only
        '{16'hffff, 1'b0, 13'h1550, 13'h0aa8, 1'b1},  // Shutdown keeps input
        '{16'h7fff, 1'b0, 13'h1550, 13'h0aa8, 1'b1},  // Idle command
        '{16'hbff8, 1'b0, 13'h1ff8, 13'h0aa8, 1'b1},  // Decoded in shutdown
        '{16'hc123, 1'b0, 13'h1ff8, 13'h1ff8, 1'b0},  // Copy, code ignored
        '{16'h8008, 1'b1, 13'h0008, 13'h0008, 1'b0},  // Two bytes, top bit set
        '{16'h5fff, 1'b0, 13'h0008, 13'h0008, 1'b0}   // Copy with junk code
    };

    sdc_dac_if sdc_dac_if_i (
        .pclk           (pclk),
        .presetn        (presetn),
        .paddr          (paddr),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .sclk           (sclk),
        .din            (din),
        .cs_n           (cs_n),
        .conv_value     (conv_value),
        .shutdown       (shutdown),
        .output_settled (output_settled)
    );

    sdc_serial_master sdc_serial_master_i (
        .sclk (sclk),
        .din  (din),
        .cs_n (cs_n)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic final_report;
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk(rd, exp, what);
        chk({31'h0, er}, 32'h0000_0000, "slave error");
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #300000;
        fail_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fail_count = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({19'h0, conv_value}, 32'h0000_0000, "conv after reset");
        chk({31'h0, shutdown}, 32'h0000_0000, "shutdown after reset");
        chk({31'h0, output_settled}, 32'h0000_0000, "settled after reset");
        rd_chk(ADDR_INPUT, 32'h0000_0000, "input after reset");
        rd_chk(ADDR_CONV, 32'h0000_0000, "conv reg after reset");
        rd_chk(ADDR_CTRL, 32'h0000_0001, "ctrl after reset");
        foreach (rows[i]) begin
            sdc_serial_master_i.send_frame(rows[i].frame, 16, rows[i].split);
            repeat (2) @(posedge pclk);
            rd_chk(ADDR_INPUT, {19'h0, rows[i].exp_in}, "input reg");
            chk({19'h0, conv_value}, {19'h0, rows[i].exp_conv}, "conv port");
            chk({31'h0, shutdown}, {31'h0, rows[i].exp_sd}, "shutdown");
        end
        // Pulses with select high must not shift
        sdc_serial_master_i.noise(16);
        sdc_serial_master_i.send_frame(16'h0000, 8, 1'b0);
        repeat (2) @(posedge pclk);
        rd_chk(ADDR_FRAME, 32'h0000_ff00, "short frame word");
        chk({31'h0, shutdown}, 32'h0000_0001, "short frame shutdown");
        chk({19'h0, conv_value}, 32'h0000_0008, "conv kept");
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
        chk({31'h0, rd[STAT_LEN_ERR]}, 32'h0000_0001, "length error set");
        chk({27'h0, rd[STAT_BITS_LSB +: 5]}, 32'h0000_0008, "short frame bits");
        chk({24'h0, rd[STAT_COUNT_LSB +: 8]}, 32'h0000_0009, "frame count");
        wr(ADDR_STATUS, 32'h0000_0002);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
        chk({31'h0, rd[STAT_LEN_ERR]}, 32'h0000_0000, "length error cleared");
        // Recall after shutdown, then settling time
        sdc_serial_master_i.send_frame(16'h4000, 16, 1'b0);
        repeat (2) @(posedge pclk);
        chk({31'h0, shutdown}, 32'h0000_0000, "recall exits");
        chk({19'h0, conv_value}, 32'h0000_0008, "recall value");
        chk({31'h0, output_settled}, 32'h0000_0000, "not yet settled");
        repeat (3900) @(posedge pclk);
        chk({31'h0, output_settled}, 32'h0000_0000, "settling");
        repeat (150) @(posedge pclk);
        chk({31'h0, output_settled}, 32'h0000_0001, "settled");
        // Link decode disabled
        wr(ADDR_CTRL, 32'h0000_0000);
        sdc_serial_master_i.send_frame(16'h0000, 16, 1'b0);
        repeat (2) @(posedge pclk);
        chk({19'h0, conv_value}, 32'h0000_0008, "decode disabled");
        wr(ADDR_CTRL, 32'h0000_0001);
        // Software command word
        wr(ADDR_SWCMD, 32'h0000_1ff8);  // Sub bits zero
        repeat (5) @(posedge pclk);
        rd_chk(ADDR_INPUT, 32'h0000_1ff8, "sw load input");
        chk({19'h0, conv_value}, 32'h0000_1ff8, "sw load conv");
        // Unmapped address
        apb(1'b0, 8'h18, 32'h0000_0000, rd, er);
        chk({31'h0, er}, 32'h0000_0001, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        // Reset in mid-run clears both registers
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({19'h0, conv_value}, 32'h0000_0000, "conv after mid reset");
        chk({31'h0, shutdown}, 32'h0000_0000, "shutdown after mid reset");
        chk({31'h0, output_settled}, 32'h0000_0000, "settled after mid reset");
        rd_chk(ADDR_INPUT, 32'h0000_0000, "input after mid reset");
        final_report();
    end

endmodule : sdc_dac_if_tb_top

// ### verif/sdc_serial_master.sv
// Behavioural serial master driving the converter's select, clock and data pins
`timescale 1ns/1ps
module sdc_serial_master (
    output logic sclk,
    output logic din,
    output logic cs_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Link timing
    localparam real HALF_NS = 62.5;  // 125 ns link clock period

    initial begin
        sclk = 1'b0;
        din  = 1'b0;
        cs_n = 1'b1;  // Own select line, idle high
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame of nbits, MSB first, optional byte gap
    task automatic send_frame(input logic [15:0] word, input int nbits, input logic split);
        #(1.3);
        cs_n = 1'b0;
        #(HALF_NS);  // Select ahead of first rising edge
        for (int i = nbits - 1; i >= 0; i--) begin  // MSB first, nbits bits
            din = word[i];
            #(HALF_NS);
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
            if (split && i == 8) begin  // Two bytes, select held low
                #(4 * HALF_NS);
            end
        end
        #(HALF_NS);
        cs_n = 1'b1;
        din  = ~din;  // Released line shows no stale value
        #(2 * HALF_NS);  // Select high time between frames
    endtask : send_frame

    ////////////////////////////////////////////////////////////////////////////
    // Clock pulses with select high and data low
    task automatic noise(input int n);
        #(1.3);
        din = 1'b0;
        for (int i = 0; i < n; i++) begin
            #(HALF_NS);
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
        end
    endtask : noise

endmodule : sdc_serial_master

// ### verilog/sdc_dac_if.sv
// Serial command front end with APB register access
//
// Functional notes
// - Command bits all ones on an accepted frame enter shutdown.
// - In shutdown the serial receive path keeps shifting and decoding.
// - Shutdown leaves the input register untouched for later recall.
// - Frames are 16 bits, MSB first: command, ten code, three sub bits.
// - With select high, clock and data activity is ignored.
// - With select low, data shifts in on each rising clock edge.
// - Decode and register transfer happen on select rising with link decode enabled, or on a software command write.
// - Low command bits 00: load input, copy to converter, leave shutdown.
// - Low command bits 01: load input, converter unchanged.
// - Low command bits 10: copy input to converter, leave shutdown.
// - Copy, shutdown, idle command ignore code bits; idle changes nothing.
// - Power-up clears input and converter registers to zero.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sdc_dac_if
    import sdc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        din,
    input  wire logic        cs_n,
    output sdc_value_t       conv_value,
    output logic             shutdown,
    output logic             output_settled
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [2:0]            pins_s;
    logic                  sclk_s;
    logic                  din_s;
    logic                  cs_n_s;
    logic                  sclk_prev;
    logic                  cs_n_prev;
    logic                  din_prev;
    logic                  sclk_rise;
    logic                  cs_rise;

    sdc_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'b100)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({cs_n, sclk, din}),
        .q       (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s  = pins_s[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev <= 1'b0;
            cs_n_prev <= 1'b1;
            din_prev  <= 1'b0;
        end else begin
            sclk_prev <= sclk_s;
            cs_n_prev <= cs_n_s;
            din_prev  <= din_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev;
    assign cs_rise   = cs_n_s & ~cs_n_prev;

    ////////////////////////////////////////////////////////////////////////
    // Shift register and bit counter

    logic [FRAME_BITS-1:0] shift_reg;
    logic [CNT_BITS-1:0]   bit_cnt;
    logic                  link_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= WORD_RESET;
        end else if (!cs_n_s && sclk_rise) begin
            // Data sampled one cycle before the clock edge is seen
            shift_reg <= {shift_reg[FRAME_BITS-2:0], din_prev};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= '0;
        end else if (cs_n_s) begin
            bit_cnt <= '0;
        end else if (sclk_rise && bit_cnt != '1) begin
            bit_cnt <= bit_cnt + 5'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command source selection

    logic                  frame_done;
    logic                  sw_pending;
    logic [FRAME_BITS-1:0] sw_word;
    logic                  apply;
    sdc_frame_t            frame;
    sdc_cmd_t              cmd_low;
    logic                  wr_en;
    logic                  rd_en;

    assign wr_en      = psel & penable & pwrite;
    assign rd_en      = psel & ~penable & ~pwrite;
    assign frame_done = cs_rise & link_en;
    assign apply      = frame_done | sw_pending;
    // Last sixteen bits shifted, whatever the count
    assign frame      = frame_done ? sdc_frame_t'(shift_reg) : sdc_frame_t'(sw_word);
    assign cmd_low    = sdc_cmd_t'({frame.command_bit_mid, frame.command_bit_low});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_pending <= 1'b0;
            sw_word    <= WORD_RESET;
        end else if (wr_en && paddr == ADDR_SWCMD) begin
            sw_pending <= 1'b1;
            sw_word    <= pwdata[FRAME_BITS-1:0];
        end else if (!frame_done) begin
            sw_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Double-buffered registers and shutdown

    sdc_value_t input_value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_value <= VALUE_RESET;
        end else if (apply && (cmd_low == SDC_LOAD_BOTH || cmd_low == SDC_LOAD_INPUT)) begin
            input_value <= {frame.code_bits, frame.sub_bit_top,
                            frame.sub_bit_mid, frame.sub_bit_low};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_value <= VALUE_RESET;
        end else if (apply && cmd_low == SDC_LOAD_BOTH) begin
            conv_value <= {frame.code_bits, frame.sub_bit_top,
                           frame.sub_bit_mid, frame.sub_bit_low};
        end else if (apply && cmd_low == SDC_COPY) begin
            conv_value <= input_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown <= 1'b0;
        end else if (apply) begin
            case (cmd_low)
                SDC_LOAD_BOTH: begin
                    shutdown <= 1'b0;
                end
                SDC_COPY: begin
                    shutdown <= 1'b0;
                end
                SDC_SHUT_IDLE: begin
                    if (frame.command_bit_top) begin
                        shutdown <= 1'b1;
                    end
                end
                default: begin
                    shutdown <= shutdown;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settling timer after reset or shutdown exit

    logic [SETTLE_BITS-1:0] settle_cnt;
    logic                   shutdown_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_prev <= 1'b0;
        end else begin
            shutdown_prev <= shutdown;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= SETTLE_BITS'(SETTLE_CYCLES);
        end else if (shutdown) begin
            settle_cnt <= SETTLE_BITS'(SETTLE_CYCLES);
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - 12'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_settled <= 1'b0;
        end else begin
            output_settled <= !shutdown && settle_cnt == '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status tracking

    logic [7:0]            frame_count;
    logic [CNT_BITS-1:0]   last_bits;
    logic [FRAME_BITS-1:0] last_frame;
    logic                  len_err;
    logic                  len_err_set;
    logic                  len_err_clr;

    assign len_err_set = frame_done && bit_cnt != CNT_BITS'(FRAME_BITS);
    assign len_err_clr = wr_en && paddr == ADDR_STATUS && pwdata[STAT_LEN_ERR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_err <= 1'b0;
        end else if (len_err_set) begin
            len_err <= 1'b1;
        end else if (len_err_clr) begin
            len_err <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_count <= '0;
            last_bits   <= '0;
            last_frame  <= WORD_RESET;
        end else if (frame_done) begin
            frame_count <= frame_count + 8'd1;
            last_bits   <= bit_cnt;
            last_frame  <= shift_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        addr_ok;

    assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_SWCMD || paddr == ADDR_STATUS
                  || paddr == ADDR_INPUT || paddr == ADDR_CONV || paddr == ADDR_FRAME;
    assign pready  = psel & penable;

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                next_prdata[CTRL_LINK_EN] = link_en;
            end
            ADDR_SWCMD: begin
                next_prdata[FRAME_BITS-1:0] = sw_word;
            end
            ADDR_STATUS: begin
                next_prdata[STAT_SHUTDOWN] = shutdown;
                next_prdata[STAT_LEN_ERR]  = len_err;
                next_prdata[STAT_CS_LEVEL] = cs_n_s;
                next_prdata[STAT_SETTLED]  = output_settled;
                next_prdata[STAT_COUNT_LSB +: 8]        = frame_count;
                next_prdata[STAT_BITS_LSB +: CNT_BITS]  = last_bits;
            end
            ADDR_INPUT: begin
                next_prdata[12:0] = input_value;
            end
            ADDR_CONV: begin
                next_prdata[12:0] = conv_value;
            end
            ADDR_FRAME: begin
                next_prdata[FRAME_BITS-1:0] = last_frame;
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    assign next_pslverr = psel & ~penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= rd_en ? next_prdata : 32'h0000_0000;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_en <= CTRL_LINK_EN_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            link_en <= pwdata[CTRL_LINK_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    shut_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && frame.command_bit_top && cmd_low == SDC_SHUT_IDLE |=> shutdown)
        else $error("shutdown command did not enter shutdown");

    shut_keeps_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && cmd_low == SDC_SHUT_IDLE |=> $stable(input_value))
        else $error("shutdown altered the input register");

    shift_active_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cs_n_s && sclk_rise |=> shift_reg == {$past(shift_reg[14:0]), $past(din_prev)})
        else $error("shift register missed a bit");

    shift_in_shut_a: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown && !cs_n_s && sclk_rise |=> shift_reg[0] == $past(din_prev))
        else $error("receive path stalled in shutdown");

    idle_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        cs_n_s |=> $stable(shift_reg) && bit_cnt == '0)
        else $error("shift activity while deselected");

    load_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && cmd_low == SDC_LOAD_BOTH
        |=> conv_value.code_bits == $past(frame.code_bits)
            && input_value == conv_value && !shutdown)
        else $error("load-both command failed");

    load_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && cmd_low == SDC_LOAD_INPUT
        |=> input_value.code_bits == $past(frame.code_bits) && $stable(conv_value))
        else $error("load-input command failed");

    copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && cmd_low == SDC_COPY |=> conv_value == $past(input_value) && !shutdown)
        else $error("copy command failed");

    idle_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
        apply && cmd_low == SDC_SHUT_IDLE && !frame.command_bit_top
        |=> $stable(input_value) && $stable(conv_value) && $stable(shutdown))
        else $error("idle command changed state");

    decode_on_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$stable(conv_value) || !$stable(input_value) |-> $past(apply))
        else $error("registers changed without a command");

    len_check_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_done && bit_cnt != 5'd16 |=> len_err)
        else $error("odd frame length not flagged");

    settle_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(shutdown) |-> !output_settled [*8])
        else $error("settled flag rose too early after shutdown exit");

    shut_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        frame_done && cmd_low == SDC_SHUT_IDLE && frame.command_bit_top);
    recall_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        shutdown && frame_done && cmd_low == SDC_COPY);
    len_cover_c: cover property (@(posedge pclk) disable iff (!presetn) len_err_set);
    sw_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        sw_pending && !frame_done);

endmodule : sdc_dac_if

// ### verilog/sdc_pkg.sv
// Constants, field layouts and carrier types of the serial converter front end
package sdc_pkg;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS   = 3;
    localparam int CODE_BITS  = 10;
    localparam int SUB_BITS   = 3;
    localparam int CNT_BITS   = 5;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SWCMD  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INPUT  = 8'h0c;
    localparam logic [7:0] ADDR_CONV   = 8'h10;
    localparam logic [7:0] ADDR_FRAME  = 8'h14;

    // Field positions
    localparam int CTRL_LINK_EN   = 0;
    localparam int STAT_SHUTDOWN  = 0;
    localparam int STAT_LEN_ERR   = 1;
    localparam int STAT_CS_LEVEL  = 2;
    localparam int STAT_SETTLED   = 3;
    localparam int STAT_COUNT_LSB = 8;
    localparam int STAT_BITS_LSB  = 16;

    // Reset values
    localparam logic        CTRL_LINK_EN_RESET = 1'b1;
    localparam logic [15:0] WORD_RESET         = 16'h0000;
    localparam logic [12:0] VALUE_RESET        = 13'h0000;

    // Output settling time
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int SETTLE_TIME_PS = 20000000;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_BITS    = 12;

    // Low two command bits
    typedef enum logic [1:0] {
        SDC_LOAD_BOTH  = 2'b00,
        SDC_LOAD_INPUT = 2'b01,
        SDC_COPY       = 2'b10,
        SDC_SHUT_IDLE  = 2'b11
    } sdc_cmd_t;

    // Serial frame, most significant bit first
    typedef struct packed {
        logic                 command_bit_top;
        logic                 command_bit_mid;
        logic                 command_bit_low;
        logic [CODE_BITS-1:0] code_bits;
        logic                 sub_bit_top;
        logic                 sub_bit_mid;
        logic                 sub_bit_low;
    } sdc_frame_t;

    // Stored converter value
    typedef struct packed {
        logic [CODE_BITS-1:0] code_bits;
        logic [SUB_BITS-1:0]  sub_bits;
    } sdc_value_t;

endpackage : sdc_pkg

// ### verilog/sdc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sdc_sync #(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : sdc_sync
